// file: rtl/tpg_regs.svh
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

// Timebase and the least gap between pulse width and pulse period.
`define TPG_CLK_PERIOD_NS 5
`define TPG_MIN_GAP_NS    20
`define TPG_MIN_GAP_CYC   ((`TPG_MIN_GAP_NS + `TPG_CLK_PERIOD_NS - 1) / `TPG_CLK_PERIOD_NS)

// Counter width for period, width, delay and spacing settings.
`define TPG_CNT_W         32

// Pulse mode encodings.
`define TPG_PM_SINGLE     1'h0
`define TPG_PM_DOUBLE     1'h1

// Trigger mode encodings.
`define TPG_TM_AUTO       3'h0
`define TPG_TM_SINGLE     3'h1
`define TPG_TM_EXT_SINGLE 3'h2
`define TPG_TM_EXT_RETRIG 3'h3
`define TPG_TM_EXT_GATED  3'h4

// Reset values.
`define TPG_RST_CNT       32'h0000_0000

`endif

// file: rtl/tpg_pkg.sv
`include "tpg_regs.svh"

package tpg_pkg;

    typedef enum logic [0:0] {
        PM_SINGLE = `TPG_PM_SINGLE,
        PM_DOUBLE = `TPG_PM_DOUBLE
    } pulse_mode_t;

    typedef enum logic [2:0] {
        TM_AUTO       = `TPG_TM_AUTO,
        TM_SINGLE     = `TPG_TM_SINGLE,
        TM_EXT_SINGLE = `TPG_TM_EXT_SINGLE,
        TM_EXT_RETRIG = `TPG_TM_EXT_RETRIG,
        TM_EXT_GATED  = `TPG_TM_EXT_GATED
    } trig_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_DELAY = 2'h1,
        ST_RUN   = 2'h2
    } gen_state_t;

    // Timing settings: pulse mode, then period, widths and delays in timebase clock cycles.
    typedef struct packed {
        pulse_mode_t           pulse_mode;
        logic [`TPG_CNT_W-1:0] period;
        logic [`TPG_CNT_W-1:0] width;
        logic [`TPG_CNT_W-1:0] width2;
        logic [`TPG_CNT_W-1:0] delay;
        logic [`TPG_CNT_W-1:0] dbl_delay;
    } timing_t;

    // Output stage settings.
    typedef struct packed {
        logic out_enable;
        logic invert;
        logic sync_seq;
    } out_cfg_t;

endpackage : tpg_pkg

// file: rtl/trigger_pulse_generator.sv
`include "tpg_regs.svh"

module trigger_pulse_generator
    import tpg_pkg::*;
(
    input  wire logic       core_clk,    // 200 MHz timebase
    input  wire logic       resetn,      // asynchronous reset, active low
    input  wire timing_t    timing,      // period, widths and delays in cycles
    input  wire trig_mode_t trig_mode,   // trigger mode select
    input  wire out_cfg_t   out_cfg,     // enable, polarity, sync marking
    input  wire logic       exec_single, // one-cycle manual execute pulse
    input  wire logic       ext_trig,    // external trigger pin
    input  wire logic       ext_gate,    // external gate pin
    output logic            mod_out,     // modulation signal to the modulator
    output logic            conn_out,    // pulse connector level
    output logic            conn_oe,     // pulse connector driven
    output logic            sync_out,    // sequence marker pulse
    output logic            cfg_error    // width too close to period
);

    typedef struct packed {
        gen_state_t            st;
        logic [`TPG_CNT_W-1:0] cnt;
        logic [`TPG_CNT_W-1:0] dcnt;
        timing_t               lat;
        logic                  trig_s1;
        logic                  trig_s2;
        logic                  trig_d;
        logic                  gate_s1;
        logic                  gate_s2;
        logic                  mod;
        logic                  conn;
        logic                  oe;
        logic                  sync;
        logic                  err;
    } core_state_t;

    localparam logic [`TPG_CNT_W:0] MIN_GAP = (`TPG_CNT_W+1)'(`TPG_MIN_GAP_CYC);

    core_state_t r;
    core_state_t n;

    logic                  trig_ev;
    logic                  cfg_ok;
    logic                  start;
    logic                  period_end;
    logic                  seq_start;

    // High level of the pattern at count c with latched settings t.
    function automatic logic pattern_hi(input logic [`TPG_CNT_W-1:0] c, input timing_t t);
        logic                  first;
        logic                  second;
        logic [`TPG_CNT_W:0]   end2;
        first  = c < t.width;
        end2   = {1'b0, t.dbl_delay} + {1'b0, t.width2};
        second = (t.pulse_mode == PM_DOUBLE) && (c >= t.dbl_delay)
                 && ({1'b0, c} < end2);
        pattern_hi = first | second;
    endfunction : pattern_hi

    always_comb begin
        n          = r;
        trig_ev    = r.trig_s2 & ~r.trig_d;
        cfg_ok     = ({1'b0, timing.width} + MIN_GAP) <= {1'b0, timing.period};
        period_end = (r.st == ST_RUN) && (r.cnt == r.lat.period - 1'b1);
        seq_start  = 1'b0;

        n.trig_s1 = ext_trig;
        n.trig_s2 = r.trig_s1;
        n.trig_d  = r.trig_s2;
        n.gate_s1 = ext_gate;
        n.gate_s2 = r.gate_s1;
        n.err     = ~cfg_ok;

        case (trig_mode)
            TM_AUTO:       start = (r.st == ST_IDLE);
            TM_SINGLE:     start = (r.st == ST_IDLE) && exec_single;
            TM_EXT_SINGLE: start = (r.st == ST_IDLE) && trig_ev;
            TM_EXT_RETRIG: start = trig_ev;
            TM_EXT_GATED:  start = (r.st == ST_IDLE) && r.gate_s2;
            default:       start = 1'b0;
        endcase
        start = start && cfg_ok;

        case (r.st)
            ST_IDLE: begin
            end
            ST_DELAY: begin
                n.dcnt = r.dcnt + 1'b1;
                if (r.dcnt == r.lat.delay - 1'b1) begin
                    n.st      = ST_RUN;
                    n.cnt     = `TPG_RST_CNT;
                    seq_start = 1'b1;
                end
            end
            ST_RUN: begin
                n.cnt = r.cnt + 1'b1;
                if (period_end) begin
                    if ((trig_mode == TM_AUTO || (trig_mode == TM_EXT_GATED && r.gate_s2)) && cfg_ok) begin
                        n.cnt     = `TPG_RST_CNT;
                        n.lat     = timing;
                        seq_start = 1'b1;
                    end else begin
                        n.st = ST_IDLE;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        if (start) begin
            n.lat  = timing;
            n.dcnt = `TPG_RST_CNT;
            n.cnt  = `TPG_RST_CNT;
            if (timing.pulse_mode == PM_SINGLE && timing.delay != `TPG_RST_CNT) begin
                n.st = ST_DELAY;
                // A restart into the delay drops a marker raised by the state it leaves.
                seq_start = 1'b0;
            end else begin
                n.st      = ST_RUN;
                seq_start = 1'b1;
            end
        end

        if (trig_mode == TM_EXT_GATED && !r.gate_s2) begin
            n.st      = ST_IDLE;
            seq_start = 1'b0;
        end

        n.mod  = (n.st == ST_RUN) && pattern_hi(n.cnt, n.lat);
        n.sync = out_cfg.sync_seq && seq_start;
        n.oe   = out_cfg.out_enable;
        n.conn = out_cfg.out_enable && (n.mod ^ out_cfg.invert);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign mod_out   = r.mod;
    assign conn_out  = r.conn;
    assign conn_oe   = r.oe;
    assign sync_out  = r.sync;
    assign cfg_error = r.err;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_period_end;
        r.st == ST_RUN && r.cnt == r.lat.period - 1'b1;
    endsequence

    sequence s_restart;
        r.st == ST_RUN && r.cnt == `TPG_RST_CNT;
    endsequence

    a_auto_repeat: assert property (s_period_end ##0 (trig_mode == TM_AUTO && cfg_ok)
        |=> s_restart) else $error("auto mode did not restart the period");
    a_oneshot_end: assert property (s_period_end ##0 (trig_mode == TM_EXT_SINGLE && !trig_ev)
        |=> r.st == ST_IDLE) else $error("one-shot mode kept running");
    a_first_width: assert property ((r.st == ST_RUN && r.lat.pulse_mode == PM_SINGLE
        && r.cnt >= r.lat.width) |-> !r.mod) else $error("first pulse too long");
    a_first_start: assert property ((r.st == ST_RUN && r.cnt == `TPG_RST_CNT
        && r.lat.width != `TPG_RST_CNT) |-> r.mod) else $error("first pulse missing");
    a_second_start: assert property ((r.st == ST_RUN && r.lat.pulse_mode == PM_DOUBLE
        && r.cnt == r.lat.dbl_delay && r.lat.width2 != `TPG_RST_CNT) |-> r.mod)
        else $error("second pulse missing");
    a_double_nodelay: assert property (r.st == ST_DELAY |-> r.lat.pulse_mode == PM_SINGLE)
        else $error("delay used in double mode");
    a_delay_done: assert property ((r.st == ST_DELAY && r.dcnt == r.lat.delay - 1'b1
        && trig_mode != TM_EXT_GATED && !trig_ev) |=> s_restart)
        else $error("delay did not end on time");
    a_gate_low: assert property ((trig_mode == TM_EXT_GATED && !r.gate_s2) |=> !r.mod)
        else $error("output active with gate low");
    a_reject_cfg: assert property ((r.st == ST_IDLE && !cfg_ok) |=> r.st == ST_IDLE)
        else $error("started with width too close to period");
    a_exec_ignored: assert property ((r.st == ST_IDLE && trig_mode == TM_EXT_SINGLE
        && !trig_ev) |=> r.st == ST_IDLE) else $error("started without trigger");
    a_sync_mark: assert property (r.sync |-> s_restart ##1 !r.sync)
        else $error("sync marker misplaced");
    a_conn_level: assert property (r.oe |-> r.conn == (r.mod ^ $past(out_cfg.invert)))
        else $error("connector polarity wrong");
    a_conn_off: assert property (!out_cfg.out_enable |=> !r.oe && !r.conn)
        else $error("connector driven while disabled");
    a_auto_start: assert property ((r.st == ST_IDLE && trig_mode == TM_AUTO && cfg_ok)
        |=> r.st != ST_IDLE) else $error("auto mode did not start");
    a_ext_start: assert property ((r.st == ST_IDLE && trig_mode == TM_EXT_SINGLE
        && trig_ev && cfg_ok) |=> r.st != ST_IDLE) else $error("external trigger ignored");
    a_exec_only: assert property ((r.st == ST_IDLE && exec_single && !trig_ev
        && (trig_mode == TM_EXT_SINGLE || trig_mode == TM_EXT_RETRIG)) |=> r.st == ST_IDLE)
        else $error("execute acted outside single mode");
    a_second_width: assert property ((r.st == ST_RUN && r.lat.pulse_mode == PM_DOUBLE
        && r.cnt >= r.lat.width && r.cnt == r.lat.dbl_delay + r.lat.width2) |-> !r.mod)
        else $error("second pulse too long");

endmodule : trigger_pulse_generator

// file: bench/ext_source.sv
module ext_source (
    input  wire logic core_clk, // timebase, used to size the trigger pulse
    input  wire logic fire,     // bench request for one trigger edge
    input  wire logic gate_req, // bench request for the gate level
    output logic      ext_trig, // trigger pin
    output logic      ext_gate  // gate pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ext_trig = 1'b0;
        ext_gate = 1'b0;
    end

    // Edges land off the clock grid, as a free-running source would.
    always @(posedge fire) begin
        #1.3;
        ext_trig = 1'b1;
        repeat (4) @(posedge core_clk);
        #2.2;
        ext_trig = 1'b0;
    end

    always @(gate_req) #2.7 ext_gate = gate_req;
endmodule : ext_source

// file: bench/trigger_pulse_generator_bench.sv
module trigger_pulse_generator_bench
    import tpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk = 1'b0;
    logic       resetn = 1'b0;
    timing_t    tm = '0;
    trig_mode_t mode = TM_AUTO;
    out_cfg_t   oc = '0;
    logic       exec_single = 1'b0;
    logic       fire = 1'b0;
    logic       gate_req = 1'b0;
    wire logic  ext_trig, ext_gate, mod_out, conn_out, conn_oe, sync_out, cfg_error;
    int         n_fail = 0;
    int         num_checks = 0;
    int         n;

    trigger_pulse_generator DUT (.core_clk, .resetn, .timing(tm), .trig_mode(mode), .out_cfg(oc),
        .exec_single, .ext_trig, .ext_gate, .mod_out, .conn_out, .conn_oe, .sync_out, .cfg_error);
    ext_source src (.core_clk, .fire, .gate_req, .ext_trig, .ext_gate);

    initial forever #2.5 core_clk = ~core_clk;

    function automatic logic exp_mod(int k);
        int p = k % tm.period;
        return (p < tm.width) || (tm.pulse_mode == PM_DOUBLE && p >= tm.dbl_delay && p < tm.dbl_delay + tm.width2);
    endfunction : exp_mod

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic setup(trig_mode_t m, logic d);
        logic [31:0] w, w2, dd;
        w = 1 + $urandom % 4;
        w2 = 1 + $urandom % 3;
        dd = w + 1 + $urandom % 3;
        @(posedge core_clk);
        resetn <= 1'b0;
        mode <= m;
        tm.pulse_mode <= pulse_mode_t'(d);
        tm.width <= w;
        tm.width2 <= w2;
        tm.dbl_delay <= dd;
        tm.delay <= $urandom % 6;
        tm.period <= dd + w2 + 4 + $urandom % 6;
        oc <= out_cfg_t'($urandom % 8);
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask : setup

    task automatic kick(bit ext);
        @(posedge core_clk);
        if (ext) fire <= 1'b1; else exec_single <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        exec_single <= 1'b0;
        @(negedge core_clk);
    endtask : kick

    task automatic wait_rise();
        n = 0;
        while (mod_out !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 400) chk(32'h1, 32'h0);
    endtask : wait_rise

    // Walks len cycles from the first pulse start; only the first act cycles may pulse.
    task automatic pattern(int len, int act);
        logic e;
        for (int k = 0; k < len; k++) begin
            e = (k < act) && exp_mod(k);
            chk(mod_out, e);
            chk(sync_out, oc.sync_seq && k < act && k % tm.period == 0);
            chk(conn_out, oc.out_enable & (e ^ oc.invert));
            chk(conn_oe, oc.out_enable);
            @(negedge core_clk);
        end
    endtask : pattern

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        #300us;
        n_fail++;
        finish_test();
    end

    initial begin
        void'($urandom(32'hdcf1));
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        for (int d = 0; d < 2; d++) begin
            setup(TM_SINGLE, d[0]);
            chk(cfg_error, 1'b0);
            @(posedge core_clk);
            mode <= TM_AUTO;
            @(negedge core_clk);
            wait_rise();
            chk(n, d ? 1 : 1 + tm.delay);
            pattern(3 * tm.period, 3 * tm.period);
            $display("auto test done");
            setup(TM_SINGLE, d[0]);
            pattern(10, 0);
            kick(1'b0);
            wait_rise();
            chk(n, d ? 0 : tm.delay);
            pattern(2 * tm.period, tm.period);
            $display("single trigger test done");
        end
        for (int m = 0; m < 2; m++) begin
            setup(m ? TM_EXT_RETRIG : TM_EXT_SINGLE, 1'b0);
            kick(1'b0);
            pattern(10, 0);
            repeat (2) begin
                kick(1'b1);
                wait_rise();
                pattern(2 * tm.period, tm.period);
            end
            $display("external trigger test done");
        end
        setup(TM_EXT_GATED, 1'b0);
        gate_req <= 1'b1;
        wait_rise();
        pattern(tm.period, tm.period);
        gate_req <= 1'b0;
        repeat (8) @(negedge core_clk);
        pattern(10, 0);
        $display("gated test done");
        setup(TM_AUTO, 1'b0);
        @(posedge core_clk);
        resetn <= 1'b0;
        tm.width <= tm.period - 3;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(negedge core_clk);
        chk(cfg_error, 1'b1);
        pattern(2 * tm.period, 0);
        $display("width limit test done");
        finish_test();
    end
endmodule : trigger_pulse_generator_bench
